// *** adc_config_and_control.sv ***
// register file, clock divider and sequencer of the SAR converter
// assumes the analog core presents a settled code and reference flags
// while convertEn is high; all register traffic on mclk
`timescale 1ns/1ns
module adc_config_and_control
    import adc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [7:0]  rdData,
    input  wire logic        hwTrigPin,
    input  wire logic        altClkPin,
    input  wire logic        asyncClkPin,
    input  wire logic [11:0] coreCode,
    input  wire logic        coreAboveHigh,
    input  wire logic        coreBelowLow,
    output logic             sampleEn,
    output logic             convertEn,
    output logic      [4:0]  convChannel,
    output logic             lowPowerSel,
    output logic      [1:0]  resolutionSel,
    output logic      [15:0] pinDisable,
    output logic             conversionDone,
    output logic             completionIrq
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0]  cfg_ff;
    logic [7:0]  sc2_ff;
    logic        conversion_complete_flag_ff;
    logic        completion_interrupt_enable_ff;
    logic        cont_ff;
    logic [4:0]  chan_ff;
    logic [11:0] result_ff;
    logic [3:0]  cvh_ff;
    logic [7:0]  cvl_ff;
    logic [7:0]  pc1_ff;
    logic [7:0]  pc2_ff;
    logic        lock_ff;
    logic [7:0]  rdData_ff;
    state_e      state_ff;
    state_e      nxt_state;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [2:0]  divCnt_ff;
    logic        half_ff;
    logic [2:0]  trigSync_ff;
    logic [2:0]  altSync_ff;
    logic [2:0]  asynSync_ff;
    logic        sampleEn_ff;
    logic        convertEn_ff;
    logic        done_ff;
    logic        irq_ff;

    logic        srcTick;
    logic        adckTick;
    logic [2:0]  divMask;
    logic        wrSc1;
    logic        swStart;
    logic        hwStart;
    logic        startReq;
    logic        abortReq;
    logic        convLast;
    logic        doneEv;
    logic [11:0] satCode;
    logic [11:0] cmpVal;
    logic        cmpPass;
    logic        capture;
    logic [4:0]  smpTicks;

    // -----------------------------------------------------------------
    // helper functions
    // -----------------------------------------------------------------
    function automatic logic [11:0] fullScale(input logic [1:0] m);
        case (m)
            MODE_12: fullScale = FULL_12;
            MODE_10: fullScale = FULL_10;
            default: fullScale = FULL_8;
        endcase
    endfunction

    function automatic logic [4:0] convTicks(input logic [1:0] m);
        case (m)
            MODE_12: convTicks = CONV_12;
            MODE_10: convTicks = CONV_10;
            default: convTicks = CONV_8;
        endcase
    endfunction

    function automatic logic isAddr(input logic [3:0] a,
                                    input logic [3:0] o);
        isAddr = (a == o);
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    // stage 0 feeds stage 1 only; edges come from stages 1 and 2
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            trigSync_ff <= 3'h0;
            altSync_ff  <= 3'h0;
            asynSync_ff <= 3'h0;
        end else if (ce) begin
            trigSync_ff <= {trigSync_ff[1:0], hwTrigPin};
            altSync_ff  <= {altSync_ff[1:0], altClkPin};
            asynSync_ff <= {asynSync_ff[1:0], asyncClkPin};
        end
    end

    // -----------------------------------------------------------------
    // conversion clock: source select and divider
    // -----------------------------------------------------------------
    // source and divider choice
    always_comb begin
        case (cfg_ff[CFG_CLKH:CFG_CLKL])
            SRC_BUS:  srcTick = 1'b1;
            SRC_BUS2: srcTick = half_ff;
            SRC_ALT:  srcTick = altSync_ff[1] & ~altSync_ff[2];
            default:  srcTick = asynSync_ff[1] & ~asynSync_ff[2];
        endcase
        case (cfg_ff[CFG_DIVH:CFG_DIVL])
            2'b00:   divMask = 3'h0;
            2'b01:   divMask = 3'h1;
            2'b10:   divMask = 3'h3;
            default: divMask = 3'h7;
        endcase
    end

    // a count left above a new, smaller mask ticks at once and wraps
    assign adckTick = srcTick && (divCnt_ff >= divMask);

    // divider counts source ticks; a short count only resyncs phase
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            divCnt_ff <= 3'h0;
            half_ff   <= 1'b0;
        end else if (ce) begin
            half_ff <= ~half_ff;
            if (srcTick) begin
                divCnt_ff <= (divCnt_ff >= divMask) ? 3'h0
                                                    : divCnt_ff + 3'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    assign wrSc1    = wrStb && isAddr(addr, OFS_SC1);
    assign swStart  = wrSc1 && !sc2_ff[SC2_TRG];
    assign hwStart  = sc2_ff[SC2_TRG] && (state_ff == ST_IDLE)
                      && trigSync_ff[1] && !trigSync_ff[2];
    assign startReq = swStart || hwStart;
    // with hardware trigger a channel write still stops the old job
    assign abortReq = wrSc1 && sc2_ff[SC2_TRG];
    assign smpTicks = cfg_ff[CFG_LSMP] ? SMP_LONG : SMP_SHORT;
    assign convLast = (cnt_ff == convTicks(cfg_ff[CFG_MODH:CFG_MODL])
                       - 5'd1);
    assign doneEv   = adckTick && (state_ff == ST_CONVERT) && convLast
                      && !startReq && !abortReq;

    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (startReq) begin
            nxt_state = ST_SAMPLE;
            nxt_cnt   = 5'h0;
        end else if (abortReq) begin
            nxt_state = ST_IDLE;
            nxt_cnt   = 5'h0;
        end else if (adckTick) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_cnt = 5'h0;
                end
                ST_SAMPLE: begin
                    if (cnt_ff == smpTicks - 5'd1) begin
                        nxt_state = ST_CONVERT;
                        nxt_cnt   = 5'h0;
                    end else begin
                        nxt_cnt = cnt_ff + 5'd1;
                    end
                end
                ST_CONVERT: begin
                    if (convLast) begin
                        nxt_state = cont_ff ? ST_SAMPLE
                                            : ST_IDLE;
                        nxt_cnt   = 5'h0;
                    end else begin
                        nxt_cnt = cnt_ff + 5'd1;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = 5'h0;
                end
            endcase
        end
    end

    // state registers and analog core strobes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 5'h0;
            sampleEn_ff  <= 1'b0;
            convertEn_ff <= 1'b0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            sampleEn_ff  <= (nxt_state == ST_SAMPLE);
            convertEn_ff <= (nxt_state == ST_CONVERT);
        end
    end

    // -----------------------------------------------------------------
    // result path: saturation, compare, capture
    // -----------------------------------------------------------------
    // reference flags win over the raw code
    always_comb begin
        if (coreAboveHigh) begin
            satCode = fullScale(cfg_ff[CFG_MODH:CFG_MODL]);
        end else if (coreBelowLow) begin
            satCode = 12'h000;
        end else begin
            satCode = coreCode & fullScale(cfg_ff[CFG_MODH:CFG_MODL]);
        end
    end

    assign cmpVal  = {cvh_ff, cvl_ff};
    assign cmpPass = !sc2_ff[SC2_CFE]
                     || (sc2_ff[SC2_CFGT] ? (satCode >= cmpVal)
                                          : (satCode < cmpVal));
    // a held pair or a failed compare drops the conversion
    assign capture = doneEv && cmpPass && !lock_ff;

    // result pair and high-first read lock
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            result_ff <= 12'h000;
            lock_ff   <= 1'b0;
        end else if (ce) begin
            if (capture) begin
                result_ff <= sc2_ff[SC2_CFE] ? satCode - cmpVal
                                             : satCode;
            end
            if (rdStb && isAddr(addr, OFS_RH)) begin
                lock_ff <= 1'b1;
            end else if (rdStb && isAddr(addr, OFS_RL)) begin
                lock_ff <= 1'b0;
            end
        end
    end

    // completion flag: a completion in the clearing cycle survives
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            conversion_complete_flag_ff <= 1'b0;
        end else if (ce) begin
            if (capture) begin
                conversion_complete_flag_ff <= 1'b1;
            end else if (wrSc1 || (rdStb && isAddr(addr, OFS_RL))) begin
                conversion_complete_flag_ff <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    // order of setup is left to software; each write takes at once
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_ff  <= RST_BYTE;
            sc2_ff  <= RST_BYTE;
            completion_interrupt_enable_ff <= 1'b0;
            cont_ff <= 1'b0;
            chan_ff <= RST_CHAN;
            cvh_ff  <= 4'h0;
            cvl_ff  <= RST_BYTE;
            pc1_ff  <= RST_BYTE;
            pc2_ff  <= RST_BYTE;
        end else if (ce && wrStb) begin
            case (addr)
                OFS_CFG: cfg_ff <= wrData;
                OFS_SC2: begin
                    // activity bit is live state; low nibble is zero
                    sc2_ff <= {1'b0, wrData[SC2_TRG:SC2_CFGT],
                               4'h0};
                end
                OFS_SC1: begin
                    completion_interrupt_enable_ff <= wrData[SC1_COMPLETION_INTERRUPT_ENABLE];
                    cont_ff <= wrData[SC1_CO];
                    chan_ff <= wrData[SC1_CHH:0];
                end
                OFS_CVH: cvh_ff <= wrData[3:0];
                OFS_CVL: cvl_ff <= wrData;
                OFS_PC1: pc1_ff <= wrData;
                OFS_PC2: pc2_ff <= wrData;
                default: cvl_ff <= cvl_ff;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // register reads, one cycle after the strobe
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdData_ff <= RST_BYTE;
        end else if (ce) begin
            rdData_ff <= 8'h00;
            if (rdStb) begin
                case (addr)
                    OFS_CFG: rdData_ff <= cfg_ff;
                    OFS_SC2: rdData_ff <= {state_ff != ST_IDLE,
                                           sc2_ff[6:0]};
                    OFS_SC1: rdData_ff <= {conversion_complete_flag_ff, completion_interrupt_enable_ff,
                                           cont_ff, chan_ff};
                    OFS_RH:  rdData_ff <= {4'h0, result_ff[11:8]};
                    OFS_RL:  rdData_ff <= result_ff[7:0];
                    OFS_CVH: rdData_ff <= {4'h0, cvh_ff};
                    OFS_CVL: rdData_ff <= cvl_ff;
                    OFS_PC1: rdData_ff <= pc1_ff;
                    OFS_PC2: rdData_ff <= pc2_ff;
                    default: rdData_ff <= 8'h00;
                endcase
            end
        end
    end

    // completion pulse and interrupt request level
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            done_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end else if (ce) begin
            done_ff <= capture;
            irq_ff  <= completion_interrupt_enable_ff && conversion_complete_flag_ff;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign rdData         = rdData_ff;
    assign sampleEn       = sampleEn_ff;
    assign convertEn      = convertEn_ff;
    assign convChannel    = chan_ff;
    assign lowPowerSel    = cfg_ff[CFG_LP];
    assign resolutionSel  = cfg_ff[CFG_MODH:CFG_MODL];
    // pin control only gates digital I/O, never the sequencer
    assign pinDisable     = {pc2_ff, pc1_ff};
    assign conversionDone = done_ff;
    assign completionIrq  = irq_ff;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_swWrite;
        wrStb && isAddr(addr, OFS_SC1) && !sc2_ff[SC2_TRG] && ce;
    endsequence

    sequence s_fired;
        capture && ce;
    endsequence

    property p_active;
        @(posedge mclk) disable iff (!nrst)
        (rdStb && isAddr(addr, OFS_SC2) && ce)
            |=> rdData[SC2_ACT] == $past(state_ff != ST_IDLE);
    endproperty
    a_active: assert property (p_active)
        else $error("activity bit wrong");

    property p_sc2Low;
        @(posedge mclk) disable iff (!nrst)
        (rdStb && isAddr(addr, OFS_SC2) && ce) |=> rdData[3:0] == 4'h0;
    endproperty
    a_sc2Low: assert property (p_sc2Low)
        else $error("reserved bits nonzero");

    property p_swRestart;
        @(posedge mclk) disable iff (!nrst)
        s_swWrite |=> (state_ff == ST_SAMPLE) && (cnt_ff == 5'h0)
                      ##1 sampleEn;
    endproperty
    a_swRestart: assert property (p_swRestart)
        else $error("software write did not restart");

    property p_noSetByWrite;
        @(posedge mclk) disable iff (!nrst)
        (wrSc1 && !capture && ce) |=> !conversion_complete_flag_ff;
    endproperty
    a_noSetByWrite: assert property (p_noSetByWrite)
        else $error("write changed completion flag");

    property p_fired;
        @(posedge mclk) disable iff (!nrst)
        s_fired |=> conversion_complete_flag_ff && conversionDone ##1 (completionIrq == completion_interrupt_enable_ff);
    endproperty
    a_fired: assert property (p_fired)
        else $error("completion not flagged");

    property p_hold;
        @(posedge mclk) disable iff (!nrst)
        (lock_ff && doneEv && ce) |=> $stable(result_ff) && !conversionDone;
    endproperty
    a_hold: assert property (p_hold)
        else $error("held result overwritten");

    property p_cmpFail;
        @(posedge mclk) disable iff (!nrst)
        (doneEv && sc2_ff[SC2_CFE] && !cmpPass && ce)
            |=> $stable(result_ff) && !conversionDone;
    endproperty
    a_cmpFail: assert property (p_cmpFail)
        else $error("failed compare stored result");

    property p_cmpUpper;
        @(posedge mclk) disable iff (!nrst)
        (doneEv && !lock_ff && sc2_ff[SC2_CFE] && sc2_ff[SC2_CFGT]
         && satCode >= cmpVal && ce) |=> conversion_complete_flag_ff;
    endproperty
    a_cmpUpper: assert property (p_cmpUpper)
        else $error("upper compare missed");

    property p_oneShot;
        @(posedge mclk) disable iff (!nrst)
        (doneEv && !cont_ff && ce) |=> state_ff == ST_IDLE;
    endproperty
    a_oneShot: assert property (p_oneShot)
        else $error("single mode kept running");

    property p_saturate;
        @(posedge mclk) disable iff (!nrst)
        (capture && coreAboveHigh && !sc2_ff[SC2_CFE] && ce)
            |=> result_ff == fullScale(resolutionSel);
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("no full-scale code");

    property p_sampleLen;
        @(posedge mclk) disable iff (!nrst)
        (state_ff == ST_SAMPLE && nxt_state == ST_CONVERT && ce)
            |-> cnt_ff == (cfg_ff[CFG_LSMP] ? SMP_LONG : SMP_SHORT) - 5'd1;
    endproperty
    a_sampleLen: assert property (p_sampleLen)
        else $error("sample length wrong");

    property p_undivided;
        @(posedge mclk) disable iff (!nrst)
        (cfg_ff[CFG_DIVH:CFG_DIVL] == 2'b00
         && cfg_ff[CFG_CLKH:CFG_CLKL] == SRC_BUS) |-> adckTick;
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("undivided bus clock not every cycle");
endmodule

// *** adc_pkg.sv ***
// constants, field layout and states for the converter control block
// assumes an 8-bit register port and one 20 MHz bus clock
//
// Function
// - configuration bit 7 selects low-power operation
// - configuration bits 6:5 divide input clock; 00 passes it undivided
// - configuration bit 4 picks 3.5 or 23.5 conversion-clock sample; the sequencer counts 4 or 24
// - configuration bits 3:2 pick resolution; 10 means 10-bit
// - configuration bits 1:0 pick divider source; 00 is bus clock
// - trigger register bit 7 reads one while converting
// - trigger register bit 6 picks software or hardware trigger
// - bit 5 enables compare, bit 4 picks its direction
// - trigger register bits 3:0 read zero; software writes zero to 1:0
// - completion flag is set by hardware; writes cannot set it
// - channel register bit 6 enables completion interrupt request
// - channel register bit 5 selects continuous or single conversions
// - channel register bits 4:0 select the input channel
// - high byte read first; pair held until low byte read
// - compare-value pair holds the compare threshold
// - pin-control bit disables pin I/O; conversions work regardless
// - each pin-control bit governs one analog pin
// - inputs beyond references saturate to full scale or zero
// - upper-limit compare completes when result at or above value
// - failed compare leaves flag clear and results untouched
package adc_pkg;
    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CFG = 4'h0;
    localparam logic [3:0] OFS_SC2 = 4'h1;
    localparam logic [3:0] OFS_SC1 = 4'h2;
    localparam logic [3:0] OFS_RH  = 4'h3;
    localparam logic [3:0] OFS_RL  = 4'h4;
    localparam logic [3:0] OFS_CVH = 4'h5;
    localparam logic [3:0] OFS_CVL = 4'h6;
    localparam logic [3:0] OFS_PC1 = 4'h7;
    localparam logic [3:0] OFS_PC2 = 4'h8;
    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int CFG_LP   = 7;
    localparam int CFG_DIVH = 6;
    localparam int CFG_DIVL = 5;
    localparam int CFG_LSMP = 4;
    localparam int CFG_MODH = 3;
    localparam int CFG_MODL = 2;
    localparam int CFG_CLKH = 1;
    localparam int CFG_CLKL = 0;
    localparam int SC2_ACT  = 7;
    localparam int SC2_TRG  = 6;
    localparam int SC2_CFE  = 5;
    localparam int SC2_CFGT = 4;
    localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
    localparam int SC1_COMPLETION_INTERRUPT_ENABLE = 6;
    localparam int SC1_CO   = 5;
    localparam int SC1_CHH  = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_CHAN = 5'h1F;
    // -----------------------------------------------------------------
    // encodings and timing
    // -----------------------------------------------------------------
    localparam logic [1:0] MODE_8   = 2'b00;
    localparam logic [1:0] MODE_12  = 2'b01;
    localparam logic [1:0] MODE_10  = 2'b10;
    localparam logic [1:0] SRC_BUS  = 2'b00;
    localparam logic [1:0] SRC_BUS2 = 2'b01;
    localparam logic [1:0] SRC_ALT  = 2'b10;
    localparam logic [1:0] SRC_ASYN = 2'b11;
    localparam int SAMPLE_SHORT_X2 = 7;
    localparam int SAMPLE_LONG_X2  = 47;
    localparam logic [4:0] SMP_SHORT = 5'((SAMPLE_SHORT_X2 + 1) / 2);
    localparam logic [4:0] SMP_LONG  = 5'((SAMPLE_LONG_X2 + 1) / 2);
    localparam logic [4:0] CONV_8    = 5'd9;
    localparam logic [4:0] CONV_10   = 5'd11;
    localparam logic [4:0] CONV_12   = 5'd13;
    localparam logic [11:0] FULL_8   = 12'h0FF;
    localparam logic [11:0] FULL_10  = 12'h3FF;
    localparam logic [11:0] FULL_12  = 12'hFFF;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_e;
endpackage

// *** adc_core_model.sv ***
// behavioural analog core facing the converter control block
// assumes the bench sets the input level and which reference is crossed
`timescale 1ns/1ns
module adc_core_model (
    input  wire logic        mclk,
    input  wire logic        convertEn,
    input  wire logic [11:0] level,
    input  wire logic [1:0]  refSide,
    output logic      [11:0] coreCode,
    output logic             coreAboveHigh,
    output logic             coreBelowLow
);
    // code valid only while converting; garbage otherwise so no luck helps
    initial coreCode = 12'h000;
    always @(posedge mclk) coreCode <= convertEn ? level : ~coreCode;
    // reference flags as levels, bit 1 above high, bit 0 below low
    assign coreAboveHigh = refSide[1];
    assign coreBelowLow  = refSide[0];
endmodule

// *** adc_config_and_control_bench.sv ***
// self-checking bench for the converter control block
// assumes adc_core_model on the analog side and ce tied high
`timescale 1ns/1ns
module adc_config_and_control_bench import adc_pkg::*;;
    logic        mclk = 0, nrst = 0, wrStb = 0, rdStb = 0, hwTrigPin = 0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wrData = 8'h00, rdData, v;
    logic [11:0] level = 12'h000, coreCode;
    logic [1:0]  refSide = 2'b00, resolutionSel;
    logic [4:0]  convChannel;
    logic [15:0] pinDisable, r;
    logic        sampleEn, convertEn, lowPowerSel, conversionDone;
    logic        completionIrq, coreAboveHigh, coreBelowLow;
    int          mismatches = 0, check_count = 0, n;
    logic [1:0]  modes [4] = '{MODE_8, MODE_10, MODE_12, MODE_12};
    logic [11:0] fulls [4] = '{FULL_8, FULL_10, FULL_12, 12'h000};
    // ----------------------------------------------------------------
    // clock, design and analog partner
    // ----------------------------------------------------------------
    always #25 mclk = ~mclk;
    adc_config_and_control dut_u (.mclk(mclk), .nrst(nrst), .ce(1'b1),
        .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(rdData), .hwTrigPin(hwTrigPin), .altClkPin(1'b0),
        .asyncClkPin(1'b0), .coreCode(coreCode),
        .coreAboveHigh(coreAboveHigh), .coreBelowLow(coreBelowLow),
        .sampleEn(sampleEn), .convertEn(convertEn),
        .convChannel(convChannel), .lowPowerSel(lowPowerSel),
        .resolutionSel(resolutionSel), .pinDisable(pinDisable),
        .conversionDone(conversionDone), .completionIrq(completionIrq));
    adc_core_model core_u (.mclk(mclk), .convertEn(convertEn),
        .level(level), .refSide(refSide), .coreCode(coreCode),
        .coreAboveHigh(coreAboveHigh), .coreBelowLow(coreBelowLow));
    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk); addr <= a; wrData <= d; wrStb <= 1'b1;
        @(posedge mclk); wrStb <= 1'b0;
    endtask
    // read data exists only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge mclk); addr <= a; rdStb <= 1'b1;
        @(posedge mclk); rdStb <= 1'b0;
        @(negedge mclk); v = rdData;
    endtask
    task rc(input logic [3:0] a, input logic [7:0] e);
        rd(a); chk({8'h00, v}, {8'h00, e});
        // read data stands one cycle only, then returns to zero
        @(negedge mclk); chk({8'h00, rdData}, 16'h0000);
    endtask
    // bounded wait; 100 means no pulse was seen
    task conv(input logic [7:0] d);
        wr(OFS_SC1, d); n = 0;
        while (n < 100 && conversionDone !== 1'b1) begin
            @(negedge mclk); n++;
        end
    endtask
    task res; rd(OFS_RH); r[15:8] = v; rd(OFS_RL); r[7:0] = v; endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_init;
        rc(OFS_SC1, 8'h1F); rc(OFS_CFG, 8'h00); rc(4'h9, 8'h00);
        level <= 12'h2A5; wr(OFS_CFG, 8'h98); wr(OFS_SC2, 8'h00);
        chk(lowPowerSel, 1'b1); chk(resolutionSel, MODE_10);
        wr(OFS_SC1, 8'hC1); rc(OFS_SC1, 8'h41); rc(OFS_SC2, 8'h80);
        chk({sampleEn, convertEn}, 16'h0002);
        chk(convChannel, 16'h0001);
        conv(8'hC1); chk(n > 30 && n < 46, 1'b1);
        rc(OFS_SC1, 8'hC1); chk(completionIrq, 1'b1);
        res; chk(r, 16'h02A5); rc(OFS_SC1, 8'h41);
    endtask
    task t_sat;
        for (int i = 0; i < 4; i++) begin
            refSide <= (i < 3) ? 2'b10 : 2'b01;
            wr(OFS_CFG, {4'h0, modes[i], 2'b00});
            conv(8'h01); chk(n < 25, 1'b1);
            res; chk(r, {4'h0, fulls[i]});
        end
        refSide <= 2'b00;
    endtask
    task t_lock;
        level <= 12'h055; conv(8'h01); rd(OFS_RH);
        level <= 12'h0AA; conv(8'h01); chk(n, 100);
        rc(OFS_RL, 8'h55);
    endtask
    task t_cmp;
        wr(OFS_CFG, 8'h04); wr(OFS_CVH, 8'h02); wr(OFS_CVL, 8'h00);
        wr(OFS_SC2, 8'h30); level <= 12'h100; conv(8'h01);
        chk(n, 100); rc(OFS_SC1, 8'h01);
        level <= 12'h280; conv(8'h01); chk(n < 100, 1'b1);
        res; chk(r, 16'h0080);
        wr(OFS_SC2, 8'h20); conv(8'h01); chk(n, 100);
        rc(OFS_SC2, 8'h20);
    endtask
    task t_trig;
        wr(OFS_SC2, 8'h40); wr(OFS_SC1, 8'h01); rc(OFS_SC2, 8'h40);
        @(posedge mclk); hwTrigPin <= 1'b1; n = 0;
        while (n < 100 && conversionDone !== 1'b1) begin
            @(negedge mclk); n++;
        end
        chk(n < 100, 1'b1); hwTrigPin <= 1'b0; res;
        wr(OFS_SC2, 8'h00); conv(8'h21); res; n = 0;
        while (n < 100 && conversionDone !== 1'b1) begin
            @(negedge mclk); n++;
        end
        chk(n < 100, 1'b1);
        wr(OFS_PC1, 8'h02); wr(OFS_PC2, 8'h00);
        chk(pinDisable, 16'h0002); rc(OFS_PC1, 8'h02);
    endtask
    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task summarize;
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        t_init; t_sat; t_lock; t_cmp; t_trig;
        summarize;
    end
    // hang guard well beyond the several hundred cycles needed
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        summarize;
    end
endmodule
